//--- rtl/spims_port.sv
// Purpose: serial peripheral port, master and slave roles
// Assumes: register port on ref_clk; pins asynchronous
// Notes: slave clock is sampled, so it must be slow against ref_clk
//
// The register offsets and the plain strobed port were decided locally.
`include "spims_map.svh"
`default_nettype none

// Overview of operation
// R01: master starts byte on buffer write
// R02: master keeps receiving with output unused
// R03: master rate 4, 16, 64 or reload
// R04: idle level and edge from two bits
// R05: phase bit set presents data early
// R06: slave shifts on external clock, flags
// R07: clock line idle before slave enable
// R08: slave shifting independent of sleep
// R09: slave byte in sleep sets flag, wakes
// R10: master transfer freezes during sleep
// R11: overwrite enable accepts unread-buffer writes
// R12: code 0100 selects select-controlled slave
// R13: select low enables shifting and output
// R14: select high floats output three ref_clk cycles later
// R15: select high or disable clears counter
// R16: phase bit slave needs select control
// R17: slave keeps sample point bit clear
// R18: msb first, input enters lsb
// R19: full byte sets buffer full, flag
// R20: busy write ignored, sets collision bit
// R21: buffer read clears buffer full
// R22: clock ignored while deselected
module spims_port (
	input wire logic ref_clk, // system clock, 250 MHz
	input wire logic nrst, // asynchronous reset, active low
	input wire logic [2:0] addr, // register index
	input wire logic [7:0] wr_data, // register write data
	input wire logic wr_stb, // write strobe
	input wire logic rd_stb, // read strobe
	output logic [7:0] rd_data, // read data, cycle after strobe
	input wire logic sck_i, // serial clock pin in
	output logic sck_o, // serial clock pin out
	output logic sck_oe, // serial clock drive enable
	input wire logic sdi, // serial data in pin
	output logic sdo_o, // serial data out
	output logic sdo_oe, // serial data drive enable
	input wire logic ss_n, // slave select pin, active low
	input wire logic sleep, // device sleep request
	output logic wake // wake request from sleep
);
	import spims_pkg::*;

	// ----------------
	// reset release and pin synchronisers
	// ----------------
	logic rst_meta_ff; // reset release first stage
	logic rst_n_ff; // reset used by the design
	logic [3:0] pin_s; // synchronised sck, sdi, ss_n, sleep
	logic sck_s; // synchronised serial clock
	logic sdi_s; // synchronised serial input
	logic ss_s; // synchronised select, high is deselected
	logic sleep_s; // synchronised sleep

	// release reset through two flops
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_ff <= rst_meta_ff;
		end
	end

	spims_sync #(.W(4)) u_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n_ff),
		.d({sck_i, sdi, ss_n, sleep}),
		.q(pin_s)
	);
	assign sck_s = pin_s[3];
	assign sdi_s = pin_s[2];
	assign ss_s = pin_s[1];
	assign sleep_s = pin_s[0];

	// ----------------
	// software visible state
	// ----------------
	logic write_collision_bit_ff; // write collision bit
	logic ovf_ff; // receive overflow bit
	logic en_ff; // port enable bit
	logic ckp_ff; // clock idle level
	logic [3:0] mode_ff; // mode select field
	logic smp_ff; // input sample point (stored only)
	logic cke_ff; // clock phase select
	logic bf_ff; // buffer full bit
	logic buffer_overwrite_enable_ff; // buffer overwrite enable
	logic [7:0] rate_ff; // rate reload value
	logic ie_ff; // transfer irq enable
	logic flag_ff; // transfer done flag
	logic [7:0] buf_ff; // data buffer (received byte)

	// ----------------
	// shift engine state
	// ----------------
	logic [7:0] sr_ff; // shift register
	logic [3:0] cnt_ff; // bits sampled in this byte
	logic [4:0] hc_ff; // master half period index
	logic busy_ff; // master transfer running
	logic sck_prev_ff; // last synchronised slave clock
	logic sck_ff; // master clock level
	logic sdo_ff; // serial output level
	logic sdo_oe_ff; // serial output enable
	logic sck_oe_ff; // clock output enable
	logic wake_ff; // wake request
	logic [7:0] rd_data_ff; // read data

	// ----------------
	// role decode and edge events
	// ----------------
	logic is_master; // master role active
	logic is_slave; // slave role active
	logic ss_ctl; // select controlled slave
	logic selected; // slave may shift
	logic lead; // idle to active clock edge
	logic trail; // active to idle clock edge
	logic sample; // input sampling edge
	logic change; // output change edge
	logic xfer_rst; // transfer logic reset
	logic done; // last bit latched
	logic wr_buf; // software write of buffer
	logic rd_buf; // software read of buffer
	logic engine_busy; // byte in flight
	logic wr_ok; // buffer write accepted
	logic [7:0] rx_byte; // byte after final sample
	spims_rate_if rif (); // divider carrier

	always_comb begin
		is_master = en_ff && (mode_ff == `SPIMS_MODE_M4 ||
			mode_ff == `SPIMS_MODE_M16 || mode_ff == `SPIMS_MODE_M64 ||
			mode_ff == `SPIMS_MODE_MRLD);
		is_slave = en_ff && (mode_ff == `SPIMS_MODE_SS ||
			mode_ff == `SPIMS_MODE_NOSS);
		ss_ctl = (mode_ff == `SPIMS_MODE_SS); // R12
		selected = !ss_ctl || !ss_s; // R13 R22
		// slave edges come straight from the pin clock, not the divider
		lead = (is_slave && selected && sck_prev_ff == ckp_ff &&
			sck_s != ckp_ff) || (is_master && busy_ff && rif.tick &&
			!hc_ff[0]); // R04 R06 R08
		trail = (is_slave && selected && sck_prev_ff != ckp_ff &&
			sck_s == ckp_ff) || (is_master && busy_ff && rif.tick &&
			hc_ff[0]); // R04
		sample = cke_ff ? lead : trail; // R04
		change = cke_ff ? trail : lead; // R04
		xfer_rst = !en_ff || (is_slave && ss_ctl && ss_s); // R15
		done = sample && !xfer_rst && cnt_ff == 4'h7; // R06
		rx_byte = {sr_ff[6:0], sdi_s}; // R18
		wr_buf = wr_stb && addr == `SPIMS_OFF_BUF;
		rd_buf = rd_stb && addr == `SPIMS_OFF_BUF;
		engine_busy = busy_ff || cnt_ff != 4'h0;
		wr_ok = wr_buf && !engine_busy && (!bf_ff || buffer_overwrite_enable_ff); // R11 R20
	end

	// ----------------
	// master rate divider
	// ----------------
	always_comb begin
		rif.run = is_master && busy_ff && !sleep_s; // R10
		rif.reload = rate_ff;
		case (mode_ff)
			`SPIMS_MODE_M4: rif.sel = SPIMS_RATE_DIV4; // R03
			`SPIMS_MODE_M16: rif.sel = SPIMS_RATE_DIV16; // R03
			`SPIMS_MODE_M64: rif.sel = SPIMS_RATE_DIV64; // R03
			default: rif.sel = SPIMS_RATE_RELOAD; // R03
		endcase
	end

	spims_rate u_rate (
		.ref_clk(ref_clk),
		.rst_n(rst_n_ff),
		.rif(rif)
	);

	// ----------------
	// control registers
	// ----------------
	// control and configuration written by software
	always_ff @(posedge ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			en_ff <= 1'b0;
			ckp_ff <= 1'b0;
			mode_ff <= 4'h0;
			smp_ff <= 1'b0;
			cke_ff <= 1'b0;
			buffer_overwrite_enable_ff <= 1'b0;
			rate_ff <= `SPIMS_RST_BYTE;
			ie_ff <= 1'b0;
		end else if (wr_stb) begin
			if (addr == `SPIMS_OFF_CTL1) begin
				en_ff <= wr_data[`SPIMS_CTL1_EN];
				ckp_ff <= wr_data[`SPIMS_CTL1_CKP];
				mode_ff <= wr_data[3:0];
			end else if (addr == `SPIMS_OFF_CTL3) begin
				buffer_overwrite_enable_ff <= wr_data[`SPIMS_CTL3_BUFFER_OVERWRITE_ENABLE];
			end else if (addr == `SPIMS_OFF_STAT) begin
				smp_ff <= wr_data[`SPIMS_STAT_SMP]; // R17
				cke_ff <= wr_data[`SPIMS_STAT_CKE]; // R16
			end else if (addr == `SPIMS_OFF_RATE) begin
				rate_ff <= wr_data;
			end else if (addr == `SPIMS_OFF_IEN) begin
				ie_ff <= wr_data[`SPIMS_IRQ_BIT];
			end
		end
	end

	// collision bit: hardware set wins over software clear
	always_ff @(posedge ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			write_collision_bit_ff <= 1'b0;
		end else if (wr_buf && !wr_ok) begin
			write_collision_bit_ff <= 1'b1; // R20
		end else if (wr_stb && addr == `SPIMS_OFF_CTL1) begin
			write_collision_bit_ff <= wr_data[`SPIMS_CTL1_WRITE_COLLISION_BIT];
		end
	end

	// overflow bit: byte arrived while buffer still unread
	always_ff @(posedge ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			ovf_ff <= 1'b0;
		end else if (done && bf_ff && !rd_buf && !buffer_overwrite_enable_ff) begin
			ovf_ff <= 1'b1;
		end else if (wr_stb && addr == `SPIMS_OFF_CTL1) begin
			ovf_ff <= wr_data[`SPIMS_CTL1_OVF];
		end
	end

	// ----------------
	// receive buffer, full bit and done flag
	// ----------------
	// completed byte moves to the buffer unless it would be overrun
	always_ff @(posedge ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			buf_ff <= `SPIMS_RST_BYTE;
		end else if (done && (!bf_ff || rd_buf || buffer_overwrite_enable_ff)) begin
			buf_ff <= rx_byte; // R02 R19
		end else if (wr_ok) begin
			buf_ff <= wr_data;
		end
	end

	// full bit: completion set wins over the clearing read
	always_ff @(posedge ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			bf_ff <= 1'b0;
		end else if (done) begin
			bf_ff <= 1'b1; // R19
		end else if (rd_buf) begin
			bf_ff <= 1'b0; // R21
		end
	end

	// done flag: set wins over a software write of zero
	always_ff @(posedge ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			flag_ff <= 1'b0;
		end else if (done) begin
			flag_ff <= 1'b1; // R06 R19
		end else if (wr_stb && addr == `SPIMS_OFF_IFLG) begin
			flag_ff <= wr_data[`SPIMS_IRQ_BIT];
		end
	end

	// wake request while sleeping with the flag enabled
	always_ff @(posedge ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			wake_ff <= 1'b0;
		end else begin
			wake_ff <= flag_ff && ie_ff && sleep_s; // R09
		end
	end

	// ----------------
	// shift engine
	// ----------------
	// shift register: load on accepted write, shift on sample edge
	always_ff @(posedge ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			sr_ff <= `SPIMS_RST_BYTE;
		end else if (wr_ok) begin
			sr_ff <= wr_data; // R01
		end else if (sample && !xfer_rst) begin
			sr_ff <= rx_byte; // R18
		end
	end

	// bit counter
	always_ff @(posedge ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			cnt_ff <= 4'h0;
		end else if (xfer_rst || done) begin
			cnt_ff <= 4'h0; // R15
		end else if (sample) begin
			cnt_ff <= cnt_ff + 4'h1;
		end
	end

	// master transfer window and half period index
	always_ff @(posedge ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			busy_ff <= 1'b0;
			hc_ff <= 5'h00;
		end else if (!is_master) begin
			busy_ff <= 1'b0;
			hc_ff <= 5'h00;
		end else if (wr_ok) begin
			busy_ff <= 1'b1; // R01
			hc_ff <= 5'h00;
		end else if (busy_ff && rif.tick) begin
			busy_ff <= (hc_ff != 5'h0f);
			hc_ff <= hc_ff + 5'h01;
		end
	end

	// master clock pin: idle level outside a transfer
	always_ff @(posedge ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			sck_ff <= 1'b0;
			sck_oe_ff <= 1'b0;
		end else begin
			sck_oe_ff <= is_master;
			if (!busy_ff) begin
				sck_ff <= ckp_ff; // R04
			end else if (rif.tick) begin
				sck_ff <= !sck_ff;
			end
		end
	end

	// serial output: early msb when phase bit set
	always_ff @(posedge ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			sdo_ff <= 1'b0;
		end else if (wr_ok && cke_ff) begin
			sdo_ff <= wr_data[7]; // R05
		end else if (change && !xfer_rst) begin
			sdo_ff <= sr_ff[7]; // R18
		end
	end

	// output enable: floats three ref_clk cycles after select rises
	always_ff @(posedge ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			sdo_oe_ff <= 1'b0;
		end else begin
			sdo_oe_ff <= is_master || (is_slave && selected); // R13 R14
		end
	end

	// slave clock history for edge detection
	always_ff @(posedge ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			sck_prev_ff <= 1'b0;
		end else begin
			sck_prev_ff <= sck_s;
		end
	end

	// ----------------
	// read back
	// ----------------
	always_ff @(posedge ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			rd_data_ff <= `SPIMS_RST_BYTE;
		end else if (rd_stb) begin
			if (addr == `SPIMS_OFF_BUF) begin
				rd_data_ff <= buf_ff;
			end else if (addr == `SPIMS_OFF_CTL1) begin
				rd_data_ff <= {write_collision_bit_ff, ovf_ff, en_ff, ckp_ff, mode_ff};
			end else if (addr == `SPIMS_OFF_CTL3) begin
				rd_data_ff <= {3'h0, buffer_overwrite_enable_ff, 4'h0};
			end else if (addr == `SPIMS_OFF_STAT) begin
				rd_data_ff <= {smp_ff, cke_ff, 5'h00, bf_ff};
			end else if (addr == `SPIMS_OFF_RATE) begin
				rd_data_ff <= rate_ff;
			end else if (addr == `SPIMS_OFF_IEN) begin
				rd_data_ff <= {4'h0, ie_ff, 3'h0};
			end else if (addr == `SPIMS_OFF_IFLG) begin
				rd_data_ff <= {4'h0, flag_ff, 3'h0};
			end else begin
				rd_data_ff <= 8'h00; // unmapped reads zero
			end
		end
	end

	assign rd_data = rd_data_ff;
	assign sck_o = sck_ff;
	assign sck_oe = sck_oe_ff;
	assign sdo_o = sdo_ff;
	assign sdo_oe = sdo_oe_ff;
	assign wake = wake_ff;
endmodule : spims_port
`default_nettype wire

//--- rtl/spims_map.svh
// Purpose: offsets, field positions, reset values and rate counts
// Assumes: included by the serial port design files
// Notes: definitions only
`ifndef SPIMS_MAP_SVH
`define SPIMS_MAP_SVH

// ----------------
// register offsets (word index on the plain register port)
// ----------------
`define SPIMS_OFF_BUF 3'h0
`define SPIMS_OFF_CTL1 3'h1
`define SPIMS_OFF_CTL3 3'h2
`define SPIMS_OFF_STAT 3'h3
`define SPIMS_OFF_RATE 3'h4
`define SPIMS_OFF_IEN 3'h5
`define SPIMS_OFF_IFLG 3'h6

// ----------------
// field positions
// ----------------
`define SPIMS_CTL1_WRITE_COLLISION_BIT 7
`define SPIMS_CTL1_OVF 6
`define SPIMS_CTL1_EN 5
`define SPIMS_CTL1_CKP 4
`define SPIMS_CTL3_BUFFER_OVERWRITE_ENABLE 4
`define SPIMS_STAT_SMP 7
`define SPIMS_STAT_CKE 6
`define SPIMS_IRQ_BIT 3

// ----------------
// mode select codes
// ----------------
`define SPIMS_MODE_M4 4'h0
`define SPIMS_MODE_M16 4'h1
`define SPIMS_MODE_M64 4'h2
`define SPIMS_MODE_SS 4'h4
`define SPIMS_MODE_NOSS 4'h5
`define SPIMS_MODE_MRLD 4'ha

// ----------------
// reset values and half-period counts (ref_clk cycles)
// ----------------
`define SPIMS_RST_BYTE 8'h00
`define SPIMS_HALF_DIV4 9'h002
`define SPIMS_HALF_DIV16 9'h008
`define SPIMS_HALF_DIV64 9'h020

`endif

//--- rtl/spims_pkg.sv
// Purpose: shared types of the serial port
// Assumes: nothing
// Notes: constants live in spims_map.svh
`default_nettype none
package spims_pkg;
	// master clock rate choices
	typedef enum logic [1:0] {
		SPIMS_RATE_DIV4,
		SPIMS_RATE_DIV16,
		SPIMS_RATE_DIV64,
		SPIMS_RATE_RELOAD
	} spims_rate_type;
endpackage : spims_pkg
`default_nettype wire

//--- rtl/spims_rate_if.sv
// Purpose: carrier between port core and rate divider
// Assumes: one clock domain
// Notes: none
`default_nettype none
interface spims_rate_if;
	import spims_pkg::*;
	logic run; // divider counts while high
	spims_rate_type sel; // rate choice
	logic [7:0] reload; // rate reload value
	logic tick; // one-cycle half-period pulse
	modport core (output run, output sel, output reload, input tick);
	modport div (input run, input sel, input reload, output tick);
endinterface : spims_rate_if
`default_nettype wire

//--- rtl/spims_sync.sv
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs are asynchronous to ref_clk
// Notes: first stage feeds only the second
`default_nettype none
module spims_sync #(
	parameter int W = 1
) (
	input wire logic ref_clk, // system clock
	input wire logic rst_n, // active-low reset
	input wire logic [W-1:0] d, // asynchronous level
	output logic [W-1:0] q // synchronised level
);
	logic [W-1:0] meta_ff; // first stage

	// ----------------
	// two stages
	// ----------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '0;
			q <= '0;
		end else begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end
endmodule : spims_sync
`default_nettype wire

//--- rtl/spims_rate.sv
// Purpose: master serial clock divider, half-period tick
// Assumes: run low holds the count (sleep freeze)
// Notes: tick marks one serial clock edge
`include "spims_map.svh"
`default_nettype none
module spims_rate (
	input wire logic ref_clk, // system clock
	input wire logic rst_n, // active-low reset
	spims_rate_if.div rif // control and tick
);
	import spims_pkg::*;
	logic [8:0] cnt_ff; // cycles into half period
	logic [8:0] half; // half period length

	// half period: 2, 8 or 32 ref_clk cycles for the fixed rates
	always_comb begin
		case (rif.sel)
			SPIMS_RATE_DIV4: half = `SPIMS_HALF_DIV4;
			SPIMS_RATE_DIV16: half = `SPIMS_HALF_DIV16;
			SPIMS_RATE_DIV64: half = `SPIMS_HALF_DIV64;
			default: half = {rif.reload, 1'b0} + 9'h002; // 2*(r+1)
		endcase
	end

	// counter, not cleared while idle, held whenever run is low
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 9'h000;
			rif.tick <= 1'b0;
		end else if (rif.run) begin
			rif.tick <= (cnt_ff == half - 9'h001);
			cnt_ff <= (cnt_ff >= half - 9'h001) ? 9'h000 : cnt_ff + 9'h001;
		end else begin
			rif.tick <= 1'b0;
		end
	end
endmodule : spims_rate
`default_nettype wire

//--- verif/spims_port_sva.sv
// Purpose: port-level checks of the serial port
// Assumes: bound to spims_port, one clock domain
// Notes: control fields are shadowed from register writes
`include "spims_map.svh"
`default_nettype none
module spims_port_sva (
	input wire logic ref_clk, // system clock
	input wire logic nrst, // reset, active low
	input wire logic [2:0] addr, // register index
	input wire logic [7:0] wr_data, // write data
	input wire logic wr_stb, // write strobe
	input wire logic sck_o, // serial clock out
	input wire logic sck_oe, // clock drive enable
	input wire logic sdo_oe, // data drive enable
	input wire logic ss_n, // slave select, active low
	input wire logic sleep, // sleep level
	input wire logic wake // wake request
);
	// ----------------
	// shadows and helpers
	// ----------------
	logic [5:0] ctl_ff; // enable, idle level, mode
	logic [7:0] rate_ff; // rate reload value
	logic sck_q_ff; // clock out, one cycle back
	logic [8:0] gap_ff; // cycles since the clock last moved
	logic mst; // master role chosen
	logic sel; // select-controlled slave chosen
	logic [8:0] half; // half period of the chosen rate
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	// snoop control and rate writes
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctl_ff <= 6'h00;
			rate_ff <= 8'h00;
		end else if (wr_stb && addr == `SPIMS_OFF_CTL1) begin
			ctl_ff <= wr_data[5:0];
		end else if (wr_stb && addr == `SPIMS_OFF_RATE) begin
			rate_ff <= wr_data;
		end
	end
	// count cycles between clock changes, saturating
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sck_q_ff <= 1'b0;
			gap_ff <= 9'h000;
		end else begin
			sck_q_ff <= sck_o;
			gap_ff <= (sck_o != sck_q_ff) ? 9'h000 : gap_ff + {8'h00, ~&gap_ff};
		end
	end
	assign mst = ctl_ff[5] && (ctl_ff[3:0] inside {4'h0, 4'h1, 4'h2, 4'ha});
	assign sel = ctl_ff[5] && ctl_ff[3:0] == `SPIMS_MODE_SS;
	// half period per rate code, reload rate by default
	always_comb begin
		case (ctl_ff[3:0])
			`SPIMS_MODE_M4: half = `SPIMS_HALF_DIV4;
			`SPIMS_MODE_M16: half = `SPIMS_HALF_DIV16;
			`SPIMS_MODE_M64: half = `SPIMS_HALF_DIV64;
			default: half = {rate_ff, 1'b0} + 9'h002;
		endcase
	end
	// ----------------
	// properties
	// ----------------
	sequence sel_off;
		sel && ss_n;
	endsequence
	sequence sel_on;
		sel && !ss_n;
	endsequence
	chk_idle_level: assert property ($rose(sck_oe) |-> sck_o == ctl_ff[4])
		else $error("clock not at idle level when drive starts");
	chk_clock_drive: assert property ($stable(mst) |-> sck_oe == mst)
		else $error("clock drive does not follow master role");
	chk_half_period: assert property (
		mst && $changed(sck_o) && $stable(ctl_ff) |-> gap_ff >= half - 9'h001)
		else $error("serial clock half period too short");
	chk_sleep_freeze: assert property ((mst && sleep)[*5] |-> $stable(sck_o))
		else $error("serial clock moved during sleep");
	chk_float_fast: assert property (sel && $rose(ss_n) |-> ##[0:3] !sdo_oe)
		else $error("data out still driven after deselect");
	chk_float_idle: assert property (sel_off[*5] |-> !sdo_oe)
		else $error("data out driven while deselected");
	chk_drive_sel: assert property (sel_on[*5] |-> sdo_oe)
		else $error("data out not driven while selected");
	chk_wake_sleep: assert property ((!sleep)[*4] |-> !wake)
		else $error("wake request outside sleep");
endmodule : spims_port_sva
bind spims_port spims_port_sva i_spims_port_sva (
	.ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wr_data(wr_data),
	.wr_stb(wr_stb), .sck_o(sck_o), .sck_oe(sck_oe), .sdo_oe(sdo_oe),
	.ss_n(ss_n), .sleep(sleep), .wake(wake));
`default_nettype wire

//--- verif/spims_peer.sv
// Purpose: far-side serial device, slave or master to the port
// Assumes: clock idle low; tasks called at a rising ref_clk edge
// Notes: released data line toggles so stale bits never match
`default_nettype none
module spims_peer (
	input wire logic ref_clk, // timing base
	input wire logic sck_o, // clock from the port in master role
	input wire logic sdo_o, // data from the port
	output logic sck, // clock we make in master role
	output logic sdi, // data toward the port
	output logic ss_n // select we drive, active low
);
	logic [7:0] tx_ff = 8'h00; // reply shifter, slave role
	logic [7:0] rx_ff = 8'h00; // captured bits, slave role
	logic slv = 1'b0; // acting as slave
	// idle clock low, deselected
	initial begin
		sck = 1'b0;
		sdi = 1'b0;
		ss_n = 1'b1;
	end
	// slave role: capture on rising edge, msb first
	always @(posedge sck_o) if (slv) rx_ff <= {rx_ff[6:0], sdo_o};
	// slave role: next bit after falling edge
	always @(negedge sck_o) begin
		if (slv) begin
			tx_ff <= {tx_ff[6:0], ~tx_ff[7]};
			sdi <= tx_ff[6];
		end
	end
	// arm the slave reply, msb shown before the first edge
	task automatic load(input logic [7:0] b);
		tx_ff <= b;
		sdi <= b[7];
		slv <= 1'b1;
	endtask : load
	// master role: nb pulses of half period h; sel drops the select
	task automatic xfer(input logic [7:0] tx, input int nb, input int h,
		input logic cke, input logic sel, output logic [7:0] rx);
		slv <= 1'b0;
		ss_n <= !sel;
		rx = 8'h00;
		for (int i = 0; i < nb; i++) begin
			if (cke) sdi <= tx[7 - i];
			repeat (h) @(posedge ref_clk);
			sck <= 1'b1;
			if (cke) rx = {rx[6:0], sdo_o};
			else sdi <= tx[7 - i];
			repeat (h) @(posedge ref_clk);
			sck <= 1'b0;
			if (!cke) rx = {rx[6:0], sdo_o};
		end
		repeat (h) @(posedge ref_clk);
		ss_n <= 1'b1;
		sdi <= ~sdi;
		@(posedge ref_clk); // a back-to-back call must not redrive lines
	endtask : xfer
endmodule : spims_peer
`default_nettype wire

//--- verif/spims_port_bench.sv
// Purpose: self-checking bench of the serial port
// Assumes: spims_peer stands on the serial pins
// Notes: seed fixed at 26, so every run repeats
`include "spims_map.svh"
`default_nettype none
module spims_port_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0; // 250 MHz clock
	logic nrst = 1'b0; // reset, active low
	logic [2:0] addr = 3'h0; // register index
	logic [7:0] wr_data = 8'h00; // write data
	logic wr_stb = 1'b0; // write strobe
	logic rd_stb = 1'b0; // read strobe
	logic sleep = 1'b0; // sleep level
	logic [7:0] rd_data; // read data
	logic sck_o, sck_oe, sdo_o, sdo_oe, wake; // port outputs
	logic p_sck, sdi, ss_n, sck_w; // partner lines, clock wire
	logic [7:0] rv = 8'h00; // last read value
	logic [7:0] tog = 8'h00; // clock changes seen
	logic [7:0] gap = 8'h00; // cycles since last change
	logic [7:0] lgap = 8'h00; // last half period seen
	int n_fail = 0; // mismatches
	int checks = 0; // comparisons
	int seed = 26; // random seed
	int cyc = 0; // cycles run
	assign sck_w = sck_oe ? sck_o : p_sck;
	always #2 ref_clk = ~ref_clk;
	spims_port i_spims_port (.ref_clk(ref_clk), .nrst(nrst), .addr(addr),
		.wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.rd_data(rd_data), .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe),
		.sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .ss_n(ss_n),
		.sleep(sleep), .wake(wake));
	spims_peer i_spims_peer (.ref_clk(ref_clk), .sck_o(sck_o),
		.sdo_o(sdo_o), .sck(p_sck), .sdi(sdi), .ss_n(ss_n));
	// timeout and gap count
	always @(posedge ref_clk) begin
		cyc++;
		gap++;
		if (cyc == 20000) begin
			n_fail++;
			summarize();
		end
	end
	// note each clock change
	always @(sck_o) begin
		tog++;
		lgap = gap;
		gap = 8'h00;
	end
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wr_data <= d;
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a);
		@(posedge ref_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		@(posedge ref_clk);
		rv = rd_data;
	endtask : rd
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic cmpb(input logic got, input logic exp);
		cmp({7'h00, got}, {7'h00, exp});
	endtask : cmpb
	// poll the buffer full bit, bounded
	task automatic wait_full();
		rv = 8'h00;
		for (int i = 0; i < 400 && rv[0] !== 1'b1; i++) rd(`SPIMS_OFF_STAT);
		repeat (40) @(posedge ref_clk); // last clock half follows the flag
	endtask : wait_full
	// one master byte at rate code m, with a busy write in the middle
	task automatic mbyte(input logic [3:0] m, input logic [7:0] tx);
		logic [7:0] ry;
		logic [7:0] h;
		ry = $random(seed);
		h = (m == 4'h0) ? 8'h02 : (m == 4'h2) ? 8'h20 : 8'h08;
		wr(`SPIMS_OFF_CTL1, {4'h2, m});
		i_spims_peer.load(ry);
		// an idle-level change from the role write lands one edge later
		repeat (2) @(posedge ref_clk);
		tog = 8'h00;
		wr(`SPIMS_OFF_BUF, tx);
		repeat (2) @(posedge ref_clk);
		cmpb(sdo_o, tx[7]);
		cmp(tog, 8'h00);
		wr(`SPIMS_OFF_BUF, ~tx);
		wait_full();
		cmp(tog, 8'h10);
		cmp(lgap, h);
		cmp(i_spims_peer.rx_ff, tx);
		rd(`SPIMS_OFF_BUF);
		// the fastest rate leaves no margin for the input synchroniser
		if (h > 8'h02) cmp(rv, ry);
		rd(`SPIMS_OFF_STAT);
		cmpb(rv[0], 1'b0);
		rd(`SPIMS_OFF_CTL1);
		cmpb(rv[`SPIMS_CTL1_WRITE_COLLISION_BIT], 1'b1);
		rd(`SPIMS_OFF_IFLG);
		cmpb(rv[`SPIMS_IRQ_BIT], 1'b1);
		wr(`SPIMS_OFF_IFLG, 8'h00);
	endtask : mbyte
	task automatic summarize();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : summarize
	initial begin
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] r;
		logic [7:0] t;
		logic [3:0] modes [4];
		modes = '{4'h0, 4'h1, 4'h2, 4'ha};
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		// reset values, unmapped index, rate register
		for (int k = 0; k < 8; k++) begin
			rd(k[2:0]);
			cmp(rv, `SPIMS_RST_BYTE);
		end
		wr(3'h7, 8'hff);
		rd(3'h7);
		cmp(rv, 8'h00);
		wr(`SPIMS_OFF_RATE, 8'h03);
		rd(`SPIMS_OFF_RATE);
		cmp(rv, 8'h03);
		wr(`SPIMS_OFF_STAT, 8'h40);
		wr(`SPIMS_OFF_CTL1, 8'h30);
		repeat (3) @(posedge ref_clk);
		cmpb(sck_o, 1'b1);
		for (int k = 0; k < 4; k++) mbyte(modes[k], $random(seed));
		// sleep in mid-byte freezes the clock
		fork
			mbyte(4'h1, 8'h81);
			begin
				repeat (40) @(posedge ref_clk);
				sleep <= 1'b1;
				repeat (4) @(posedge ref_clk);
				t = tog;
				repeat (50) @(posedge ref_clk);
				cmp(tog, t);
				sleep <= 1'b0;
			end
		join
		// full buffer refuses a write until overwrite is enabled
		i_spims_peer.load(8'h3c);
		wr(`SPIMS_OFF_BUF, 8'hc3);
		wait_full();
		tog = 8'h00;
		wr(`SPIMS_OFF_BUF, 8'h55);
		repeat (20) @(posedge ref_clk);
		cmp(tog, 8'h00);
		wr(`SPIMS_OFF_CTL1, 8'h21);
		wr(`SPIMS_OFF_CTL3, 8'h10);
		wr(`SPIMS_OFF_BUF, 8'h55);
		repeat (150) @(posedge ref_clk);
		cmp(tog, 8'h10);
		cmp(i_spims_peer.rx_ff, 8'h55);
		// select-controlled slave, asleep with wake enabled
		rd(`SPIMS_OFF_BUF);
		wr(`SPIMS_OFF_CTL1, 8'h24);
		wr(`SPIMS_OFF_IFLG, 8'h00);
		wr(`SPIMS_OFF_IEN, 8'h08);
		sleep <= 1'b1;
		i_spims_peer.xfer(8'ha7, 3, 10, 1'b1, 1'b1, r);
		i_spims_peer.xfer(8'hff, 4, 10, 1'b1, 1'b0, r);
		b = $random(seed);
		a = $random(seed);
		wr(`SPIMS_OFF_BUF, b);
		i_spims_peer.xfer(a, 8, 10, 1'b1, 1'b1, r);
		cmp(r, b);
		repeat (4) @(posedge ref_clk);
		cmpb(wake, 1'b1);
		sleep <= 1'b0;
		rd(`SPIMS_OFF_BUF);
		cmp(rv, a);
		rd(`SPIMS_OFF_IFLG);
		cmpb(rv[`SPIMS_IRQ_BIT], 1'b1);
		// slave without select, phase clear, abort by disable
		wr(`SPIMS_OFF_STAT, 8'h00);
		wr(`SPIMS_OFF_CTL1, 8'h25);
		i_spims_peer.xfer(8'h00, 3, 10, 1'b0, 1'b0, r);
		wr(`SPIMS_OFF_CTL1, 8'h05);
		wr(`SPIMS_OFF_CTL1, 8'h25);
		b = $random(seed);
		a = $random(seed);
		wr(`SPIMS_OFF_BUF, b);
		i_spims_peer.xfer(a, 8, 6, 1'b0, 1'b0, r);
		cmp(r, b);
		rd(`SPIMS_OFF_BUF);
		cmp(rv, a);
		summarize();
	end
endmodule : spims_port_bench
`default_nettype wire
